// ---- hw/receive_signaling_payload_ctrl.sv ----
`timescale 1ns/1ns
module receive_signaling_payload_ctrl #(
    parameter logic [3:0] LINK       = 4'h0,
    parameter int         FIFO_DEPTH = 8
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // line format
    input  wire logic        e1_mode,
    input  wire logic [1:0]  t1_format,
    // received stream from the framer
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic [4:0]  rx_channel,
    input  wire logic [7:0]  rx_data,
    input  wire logic [3:0]  rx_sig,
    input  wire logic        rx_frame_start,
    input  wire logic        rx_mf_first,
    // backplane stream
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic      [4:0]  out_channel,
    output logic      [7:0]  out_data,
    output logic      [7:0]  backplane_signaling_out,
    // shared pattern test configuration
    output logic      [7:0]  pattern_test_config
);
    localparam int WORD_W = 21;

    // refuse too small a buffer
    if (FIFO_DEPTH < 2) begin : g_check
        $error("receive_signaling_payload_ctrl: FIFO_DEPTH too small");
    end

    typedef enum logic {
        ACC_IDLE,
        ACC_RUN
    } acc_state_t;

    typedef struct packed {
        logic [7:0]       test_cfg;
        logic [7:0]       cfg;
        logic [7:0]       en;
        logic [7:0]       acc_ctl;
        logic [7:0]       acc_data;
        logic             busy;
        acc_state_t       acc;
        logic [31:0][3:0] snap;
        logic [2:0]       mw_next;
        logic [2:0]       mw_cur;
        logic [7:0]       rdata;
        logic             o_valid;
        logic [4:0]       o_ch;
        logic [7:0]       o_data;
        logic [7:0]       o_sig;
    } top_state_t;

    top_state_t st_reg;
    top_state_t st_next;

    store_if sif ();

    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic [WORD_W-1:0] fifo_in_data;
    logic [WORD_W-1:0] fifo_out_data;
    logic              accept;
    logic              link_hit;
    logic              id_ok;

    // indirect entry store
    ind_store u_store (
        .clk   (clk),
        .rst_n (rst_n),
        .sif   (sif.owner)
    );

    // buffer before the output stage
    stream_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (rx_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // outputs straight from flops
    assign rx_ready                = fifo_in_ready;
    assign reg_rdata               = st_reg.rdata;
    assign out_valid               = st_reg.o_valid;
    assign out_channel             = st_reg.o_ch;
    assign out_data                = st_reg.o_data;
    assign backplane_signaling_out = st_reg.o_sig;
    assign pattern_test_config     = st_reg.test_cfg;

    // handshake terms
    assign accept         = rx_valid & fifo_in_ready;
    assign fifo_out_ready = ~st_reg.o_valid | out_ready;
    assign link_hit       = reg_addr[11:8] == LINK;

    // indirect address valid for mode
    function automatic logic id_valid(input logic [6:0] a, input logic e1);
        if (a[6:5] == 2'h3) begin
            return 1'b0;
        end
        if (!e1) begin
            return a[4:0] >= payload_pkg::T1_FIRST_CH && a[4:0] <= payload_pkg::T1_LAST_CH;
        end
        if (a[6:5] == payload_pkg::REGION_SIG) begin
            return a[4:0] != payload_pkg::E1_SIG_TS0 && a[4:0] != payload_pkg::E1_SIG_TS16;
        end
        return 1'b1;
    endfunction

    // indirect port drive
    assign id_ok          = id_valid(st_reg.acc_ctl[6:0], e1_mode);
    assign sif.host_addr  = st_reg.acc_ctl[6:0];
    assign sif.host_wdata = st_reg.acc_data;
    assign sif.host_we    = st_reg.acc == ACC_RUN && !st_reg.acc_ctl[payload_pkg::BIT_RWN]
                            && id_ok;
    assign sif.ch         = rx_channel;

    // word path, registers, output stage
    always_comb begin
        logic       master;
        logic       t1_fmt_ok;
        logic       snap_on;
        logic       nibble_placement_select_on;
        logic [2:0] subst;
        logic [2:0] mw_idx;
        logic [7:0] d;
        logic [3:0] s;
        logic [7:0] sig_byte;

        st_next   = st_reg;
        master    = st_reg.en[payload_pkg::BIT_MASTER];
        t1_fmt_ok = !e1_mode && t1_format != payload_pkg::FMT_DM;
        snap_on   = master && st_reg.cfg[payload_pkg::BIT_SNAP] && t1_fmt_ok | e1_mode;
        nibble_placement_select_on   = master && st_reg.en[payload_pkg::BIT_NIBBLE_PLACEMENT_SELECT] && !e1_mode
                    && (t1_format == payload_pkg::FMT_ESF
                        || t1_format == payload_pkg::FMT_SLC96);
        subst     = (st_reg.cfg[2:0] != payload_pkg::SUBST_NONE) ? st_reg.cfg[2:0]
                    : sif.ctrl[2:0];
        mw_idx    = rx_frame_start ? st_reg.mw_next : st_reg.mw_cur;
        d         = rx_data;
        s         = rx_sig;
        sig_byte  = {4'h0, rx_sig};

        if (master) begin
            // data substitution
            unique case (subst)
                payload_pkg::SUBST_DTRK:  d = sif.dtrk;
                payload_pkg::SUBST_ALAW:  d = payload_pkg::ALAW_MW[mw_idx];
                payload_pkg::SUBST_MULAW: d = payload_pkg::MULAW_MW[mw_idx];
                default:                  d = rx_data;
            endcase

            // sign, odd and even inversions
            d = d ^ (sif.ctrl[payload_pkg::BIT_SIGN_BIT_INVERT] ? payload_pkg::MASK_SIGN : 8'h00);
            d = d ^ (sif.ctrl[payload_pkg::BIT_ODD_BITS_INVERT] ? payload_pkg::MASK_ODD : 8'h00);
            d = d ^ (sif.ctrl[payload_pkg::BIT_EVEN_BITS_INVERT] ? payload_pkg::MASK_EVEN : 8'h00);

            // fixed signaling, t1 sf/esf/slc-96 only
            if (st_reg.en[payload_pkg::BIT_FIX] && t1_fmt_ok) begin
                s = {4{st_reg.en[payload_pkg::BIT_POL]}};
            end

            // trunk conditioning, overrides fixed signaling, snapshot overrides it
            if (st_reg.cfg[payload_pkg::BIT_GSTRK] || sif.sig[payload_pkg::BIT_CHANNEL_SIG_CONDITIONING_EN]) begin
                s = sif.sig[3:0];
            end

            // snapshot held over the multiframe
            if (snap_on && !rx_mf_first) begin
                s = st_reg.snap[rx_channel];
            end

            // nibble placement is applied last
            sig_byte = nibble_placement_select_on ? {4'h0, s[3:2], 2'b00} : {4'h0, s};
        end

        fifo_in_data = {rx_channel, d, sig_byte};

        // snapshot capture, milliwatt phase
        if (accept) begin
            if (snap_on && rx_mf_first) begin
                st_next.snap[rx_channel] = s;
            end
            if (rx_frame_start) begin
                st_next.mw_cur  = st_reg.mw_next;
                st_next.mw_next = st_reg.mw_next + 3'h1;
            end
        end

        // indirect access sequencer
        unique case (st_reg.acc)
            ACC_IDLE: begin
                if (st_reg.busy) begin
                    st_next.acc = ACC_RUN;
                end
            end
            ACC_RUN: begin
                if (st_reg.acc_ctl[payload_pkg::BIT_RWN]) begin
                    st_next.acc_data = id_ok ? sif.host_rdata : 8'h00;
                end
                st_next.busy = 1'b0;
                st_next.acc  = ACC_IDLE;
            end
        endcase

        // writes, access regs frozen while busy
        if (reg_wr && link_hit) begin
            unique case (reg_addr[7:0])
                payload_pkg::OFF_TEST_CFG: st_next.test_cfg = reg_wdata;
                payload_pkg::OFF_CONFIG:   st_next.cfg = reg_wdata;
                payload_pkg::OFF_ENABLE:   st_next.en = reg_wdata;
                payload_pkg::OFF_CONTROL: begin
                    if (!st_reg.busy) begin
                        st_next.acc_ctl = reg_wdata;
                        st_next.busy    = 1'b1;
                    end
                end
                payload_pkg::OFF_DATA: begin
                    if (!st_reg.busy) begin
                        st_next.acc_data = reg_wdata;
                    end
                end
                default: ;
            endcase
        end

        // reads, one cycle later
        if (reg_rd) begin
            st_next.rdata = 8'h00;
            if (link_hit) begin
                unique case (reg_addr[7:0])
                    payload_pkg::OFF_TEST_CFG: st_next.rdata = st_reg.test_cfg;
                    payload_pkg::OFF_CONFIG:   st_next.rdata = st_reg.cfg;
                    payload_pkg::OFF_ENABLE:   st_next.rdata = st_reg.en;
                    payload_pkg::OFF_CONTROL:  st_next.rdata = st_reg.acc_ctl;
                    payload_pkg::OFF_DATA:     st_next.rdata = st_reg.acc_data;
                    payload_pkg::OFF_STATUS: begin
                        st_next.rdata = 8'h00;
                        st_next.rdata[payload_pkg::BIT_BUSY] = st_reg.busy;
                    end
                    default:                   st_next.rdata = 8'h00;
                endcase
            end
        end

        // backplane output stage
        if (fifo_out_ready) begin
            st_next.o_valid = fifo_out_valid;
            if (fifo_out_valid) begin
                st_next.o_ch   = fifo_out_data[20:16];
                st_next.o_data = fifo_out_data[15:8];
                st_next.o_sig  = fifo_out_data[7:0];
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// ---- common/payload_pkg.sv ----
package payload_pkg;

    // register offsets within one link, link number is the leading digit
    localparam logic [7:0] OFF_TEST_CFG = 8'hC7;
    localparam logic [7:0] OFF_STATUS   = 8'hCD;
    localparam logic [7:0] OFF_CONTROL  = 8'hCE;
    localparam logic [7:0] OFF_DATA     = 8'hCF;
    localparam logic [7:0] OFF_CONFIG   = 8'hD0;
    localparam logic [7:0] OFF_ENABLE   = 8'hD1;
    localparam logic [7:0] REG_RESET    = 8'h00;

    // field positions
    localparam int BIT_BUSY   = 0;
    localparam int BIT_RWN    = 7;
    localparam int BIT_SNAP   = 3;
    localparam int BIT_GSTRK  = 4;
    localparam int BIT_MASTER = 0;
    localparam int BIT_FIX    = 1;
    localparam int BIT_POL    = 2;
    localparam int BIT_NIBBLE_PLACEMENT_SELECT   = 3;
    localparam int BIT_SIGN_BIT_INVERT   = 3;
    localparam int BIT_ODD_BITS_INVERT   = 4;
    localparam int BIT_EVEN_BITS_INVERT   = 5;
    localparam int BIT_CHANNEL_SIG_CONDITIONING_EN = 4;

    // indirect regions, upper two address bits
    localparam logic [1:0] REGION_CTRL = 2'h0;
    localparam logic [1:0] REGION_DTRK = 2'h1;
    localparam logic [1:0] REGION_SIG  = 2'h2;
    localparam logic [4:0] T1_FIRST_CH = 5'h01;
    localparam logic [4:0] T1_LAST_CH  = 5'h18;
    localparam logic [4:0] E1_SIG_TS0  = 5'h00;
    localparam logic [4:0] E1_SIG_TS16 = 5'h10;

    // substitution selects
    localparam logic [2:0] SUBST_NONE  = 3'h0;
    localparam logic [2:0] SUBST_DTRK  = 3'h1;
    localparam logic [2:0] SUBST_ALAW  = 3'h2;
    localparam logic [2:0] SUBST_MULAW = 3'h3;

    // inversion masks
    localparam logic [7:0] MASK_SIGN = 8'h80;
    localparam logic [7:0] MASK_ODD  = 8'hAA;
    localparam logic [7:0] MASK_EVEN = 8'h55;

    // milliwatt bytes, entry 0 is the first byte, bit 0 is the lsb
    localparam logic [7:0][7:0] ALAW_MW =
        {8'h2D, 8'h85, 8'h85, 8'h2D, 8'h2C, 8'h84, 8'h84, 8'h2C};
    localparam logic [7:0][7:0] MULAW_MW =
        {8'h79, 8'hD1, 8'hD1, 8'h79, 8'h78, 8'hD0, 8'hD0, 8'h78};

    // t1/j1 framing formats
    localparam logic [1:0] FMT_SF    = 2'h0;
    localparam logic [1:0] FMT_ESF   = 2'h1;
    localparam logic [1:0] FMT_SLC96 = 2'h2;
    localparam logic [1:0] FMT_DM    = 2'h3;

endpackage

// ---- common/store_if.sv ----
`timescale 1ns/1ns
interface store_if;
    logic [6:0] host_addr;
    logic       host_we;
    logic [7:0] host_wdata;
    logic [7:0] host_rdata;
    logic [4:0] ch;
    logic [7:0] ctrl;
    logic [7:0] dtrk;
    logic [7:0] sig;
    modport owner (input host_addr, host_we, host_wdata, ch,
                   output host_rdata, ctrl, dtrk, sig);
    modport user (output host_addr, host_we, host_wdata, ch,
                  input host_rdata, ctrl, dtrk, sig);
endinterface

// ---- hw/stream_fifo.sv ----
`timescale 1ns/1ns
module stream_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // refuse unusable sizes
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_check
        $error("stream_fifo: bad DEPTH");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 count;
        logic                        full;
    } fifo_state_t;

    fifo_state_t st_reg;
    fifo_state_t st_next;
    logic        push;
    logic        pop;

    assign in_ready  = ~st_reg.full;
    assign out_valid = st_reg.count != '0;
    assign out_data  = st_reg.mem[st_reg.rd];

    // pointer and occupancy update
    always_comb begin
        st_next = st_reg;
        push = in_valid & ~st_reg.full;
        pop  = out_valid & out_ready;
        if (push) begin
            st_next.mem[st_reg.wr] = in_data;
            st_next.wr = st_reg.wr + 1'b1;
        end
        if (pop) begin
            st_next.rd = st_reg.rd + 1'b1;
        end
        st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
        st_next.full  = st_next.count == (AW+1)'(DEPTH);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// ---- hw/ind_store.sv ----
`timescale 1ns/1ns
module ind_store (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host and channel lookups
    store_if.owner   sif
);
    typedef struct packed {
        logic [127:0][7:0] mem;
    } store_state_t;

    store_state_t st_reg;
    store_state_t st_next;

    // host port and three per-channel lookups
    assign sif.host_rdata = st_reg.mem[sif.host_addr];
    assign sif.ctrl = st_reg.mem[{payload_pkg::REGION_CTRL, sif.ch}];
    assign sif.dtrk = st_reg.mem[{payload_pkg::REGION_DTRK, sif.ch}];
    assign sif.sig  = st_reg.mem[{payload_pkg::REGION_SIG, sif.ch}];

    always_comb begin
        st_next = st_reg;
        if (sif.host_we) begin
            st_next.mem[sif.host_addr] = sif.host_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// ---- verification/payload_ctrl_chk.sv ----
`timescale 1ns/1ns
module payload_ctrl_chk #(
    parameter logic [3:0] LINK       = 4'h0,
    parameter int         FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic [7:0]  pattern_test_config,
    // streams
    input wire logic        rx_valid,
    input wire logic        rx_ready,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic [4:0]  out_channel,
    input wire logic [7:0]  out_data,
    input wire logic [7:0]  backplane_signaling_out
);
    logic [4:0] fill_reg;
    logic       mine;
    logic       mapped;
    logic       cfg_hit;
    // words taken in but not yet handed on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fill_reg <= 5'h00;
        end else begin
            fill_reg <= fill_reg + 5'(rx_valid && rx_ready) - 5'(out_valid && out_ready);
        end
    end
    // address decode seen from outside
    assign mine    = reg_addr[11:8] == LINK;
    assign mapped  = reg_addr[7:0] inside {8'hC7, 8'hCD, 8'hCE, 8'hCF, 8'hD0, 8'hD1};
    assign cfg_hit = mine && reg_addr[7:0] == payload_pkg::OFF_TEST_CFG;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    foreign_read_a: assert property (reg_rd && !mine |=> reg_rdata == 8'h00)
        else $error("foreign read");
    unmapped_read_a: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read");
    cfg_write_a: assert property (reg_wr && cfg_hit |=> pattern_test_config == $past(reg_wdata))
        else $error("config write lost");
    cfg_hold_a: assert property (!(reg_wr && cfg_hit) |=> $stable(pattern_test_config))
        else $error("config changed");
    cfg_read_a: assert property (reg_rd && !reg_wr && cfg_hit |=> reg_rdata == pattern_test_config)
        else $error("config read");
    out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)
        && $stable(out_channel) && $stable(backplane_signaling_out))
        else $error("word moved");
    prompt_out_a: assert property (rx_valid && rx_ready && !out_valid |-> ##[1:2] out_valid)
        else $error("word late");
    fill_bound_a: assert property (fill_reg <= 5'(FIFO_DEPTH + 1))
        else $error("overfill");
    full_only_a: assert property (!rx_ready |-> fill_reg >= 5'(FIFO_DEPTH))
        else $error("early refusal");
    no_phantom_a: assert property (out_valid |-> fill_reg != 5'h00)
        else $error("phantom word");
endmodule
bind receive_signaling_payload_ctrl payload_ctrl_chk #(.LINK(LINK), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pattern_test_config(pattern_test_config),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .out_valid(out_valid), .out_ready(out_ready),
    .out_channel(out_channel), .out_data(out_data),
    .backplane_signaling_out(backplane_signaling_out));

// ---- verification/backplane_sink.sv ----
`timescale 1ns/1ns
module backplane_sink (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // pace: 0 prompt, 1 slow, 2 stalled
    input  wire logic [1:0] pace,
    // backplane handshake
    output logic            out_ready
);
    logic toggle_reg;
    // ready follows the pace, changed just after each edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            toggle_reg <= 1'b0;
            out_ready  <= 1'b0;
        end else begin
            toggle_reg <= !toggle_reg;
            out_ready  <= (pace == 2'h0) || (pace == 2'h1 && toggle_reg);
        end
    end
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic       e1;
        logic [6:0] a;
        logic [7:0] d;
        logic [7:0] x;
    } acc_t;
    logic        clk, rst_n, reg_wr, reg_rd, e1_mode, rx_valid, rx_ready;
    logic        rx_frame_start, rx_mf_first, out_valid, out_ready;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, rx_data, out_data, backplane_signaling_out;
    logic [7:0]  pattern_test_config, v;
    logic [4:0]  rx_channel, out_channel;
    logic [3:0]  rx_sig;
    logic [1:0]  t1_format, pace;
    logic [7:0]  got_d[$];
    logic [7:0]  got_s[$];
    logic [4:0]  got_c[$], sent_c[$];
    int          err_count;
    int          checked;
    acc_t        tbl [12];
    logic [7:0]  mw [8];
    logic [7:0]  plc [4];

    receive_signaling_payload_ctrl u_receive_signaling_payload_ctrl (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .e1_mode(e1_mode), .t1_format(t1_format),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_channel(rx_channel), .rx_data(rx_data),
        .rx_sig(rx_sig), .rx_frame_start(rx_frame_start), .rx_mf_first(rx_mf_first),
        .out_valid(out_valid), .out_ready(out_ready), .out_channel(out_channel),
        .out_data(out_data), .backplane_signaling_out(backplane_signaling_out),
        .pattern_test_config(pattern_test_config));
    backplane_sink u_backplane_sink (.clk(clk), .rst_n(rst_n), .pace(pace), .out_ready(out_ready));

    // clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // collects every word the backplane takes
    always @(posedge clk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            got_d.push_back(out_data);
            got_s.push_back(backplane_signaling_out);
            got_c.push_back(out_channel);
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic fail(input string what);
        err_count++;
        $display("BAD %s expected 1 seen 0", what);
        final_report();
    endtask

    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= {4'h0, off};
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] link, input logic [7:0] off, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= {link, off};
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // polls status until the indirect access is finished
    task automatic idle_wait();
        logic [7:0] s;
        for (int i = 0; i < 10; i++) begin
            rd(4'h0, payload_pkg::OFF_STATUS, s);
            if (s[payload_pkg::BIT_BUSY] === 1'b0) return;
        end
        fail("busy clear");
    endtask

    task automatic iw(input logic [6:0] a, input logic [7:0] d);
        wr(payload_pkg::OFF_DATA, d);
        wr(payload_pkg::OFF_CONTROL, {1'b0, a});
        idle_wait();
    endtask

    task automatic ir(input logic [6:0] a, output logic [7:0] d);
        wr(payload_pkg::OFF_CONTROL, {1'b1, a});
        idle_wait();
        rd(4'h0, payload_pkg::OFF_DATA, d);
    endtask

    task automatic send(input logic [4:0] ch, input logic [7:0] d, input logic [3:0] s,
                        input logic fs, input logic mf);
        int i;
        @(posedge clk);
        rx_channel     <= ch;
        rx_data        <= d;
        rx_sig         <= s;
        rx_frame_start <= fs;
        rx_mf_first    <= mf;
        rx_valid       <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (rx_ready === 1'b1) break;
        end
        rx_valid <= 1'b0;
        sent_c.push_back(ch);
        if (i == 40) fail("rx_ready");
    endtask

    task automatic expect_out(input logic [7:0] d, input logic [7:0] s);
        int i;
        for (i = 0; i < 40 && got_d.size() == 0; i++) begin
            @(posedge clk);
        end
        if (i == 40) fail("out_valid");
        check("out_data", got_d.pop_front(), d);
        check("signaling", got_s.pop_front(), s);
        check("channel", {3'h0, got_c.pop_front()}, {3'h0, sent_c.pop_front()});
    endtask

    initial begin
        {rst_n, reg_wr, reg_rd, e1_mode, rx_valid, rx_frame_start, rx_mf_first} = '0;
        {reg_addr, reg_wdata, rx_data, rx_channel, rx_sig, pace} = '0;
        t1_format = payload_pkg::FMT_ESF;
        err_count = 0;
        checked = 0;
        tbl = '{{1'b0, 7'h18, 8'h38, 8'h38}, {1'b0, 7'h00, 8'h11, 8'h00},
                {1'b0, 7'h19, 8'h11, 8'h00}, {1'b0, 7'h21, 8'hC3, 8'hC3},
                {1'b0, 7'h20, 8'h44, 8'h00}, {1'b0, 7'h41, 8'h1A, 8'h1A},
                {1'b0, 7'h59, 8'h0F, 8'h00}, {1'b1, 7'h00, 8'h02, 8'h02},
                {1'b1, 7'h3F, 8'h66, 8'h66}, {1'b1, 7'h50, 8'h1F, 8'h00},
                {1'b1, 7'h5F, 8'h13, 8'h13}, {1'b0, 7'h61, 8'h01, 8'h00}};
        mw = '{8'h78, 8'hD0, 8'hD0, 8'h78, 8'h79, 8'hD1, 8'hD1, 8'h79};
        plc = '{8'h0B, 8'h08, 8'h08, 8'h0B};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // direct registers: reset values, shared test config, refusals
        foreach (mw[i]) begin
            rd(4'h0, 8'hCD + 8'(i), v);
            check("reset value", v, payload_pkg::REG_RESET);
        end
        wr(8'hC7, 8'hA5);
        rd(4'h0, 8'hC7, v);
        check("test config", v, 8'hA5);
        check("test config port", pattern_test_config, 8'hA5);
        rd(4'h1, 8'hC7, v);
        check("other link", v, 8'h00);
        wr(8'hC0, 8'h5A);
        rd(4'h0, 8'hC0, v);
        check("unmapped", v, 8'h00);
        wr(8'hD1, 8'h0F);
        rd(4'h0, 8'hD1, v);
        check("control enable", v, 8'h0F);
        $display("test registers done");
        // indirect map per line mode
        foreach (tbl[i]) begin
            @(posedge clk);
            e1_mode <= tbl[i].e1;
            iw(tbl[i].a, tbl[i].d);
            ir(tbl[i].a, v);
            check("indirect", v, tbl[i].x);
        end
        @(posedge clk);
        e1_mode <= 1'b0;
        iw(7'h43, 8'h06);
        $display("test indirect done");
        // milliwatt sequence with wrap
        wr(8'hD1, 8'h01);
        wr(8'hD0, {5'h00, payload_pkg::SUBST_MULAW});
        for (int i = 0; i < 9; i++) begin
            send(5'h02, 8'h00, 4'h0, 1'b1, 1'b0);
            expect_out(mw[i % 8], 8'h00);
        end
        wr(8'hD0, 8'h00);
        iw(7'h05, 8'h3A);
        send(5'h05, 8'h00, 4'h0, 1'b1, 1'b0);
        expect_out(8'hFB, 8'h00);
        $display("test milliwatt done");
        // data trunk code and per-channel or global signaling trunk
        wr(8'hD0, {5'h00, payload_pkg::SUBST_DTRK});
        send(5'h01, 8'h55, 4'h5, 1'b0, 1'b0);
        expect_out(8'hC3, 8'h0A);
        send(5'h03, 8'h55, 4'h5, 1'b0, 1'b0);
        expect_out(8'h00, 8'h05);
        wr(8'hD0, 8'h10);
        send(5'h03, 8'h55, 4'h5, 1'b0, 1'b0);
        expect_out(8'h55, 8'h06);
        wr(8'hD1, 8'h00);
        wr(8'hD0, 8'h13);
        send(5'h01, 8'h55, 4'h5, 1'b0, 1'b0);
        expect_out(8'h55, 8'h05);
        $display("test trunk done");
        // snapshot, and its absence in dm
        wr(8'hD1, 8'h01);
        wr(8'hD0, 8'h08);
        send(5'h03, 8'h11, 4'h9, 1'b0, 1'b1);
        expect_out(8'h11, 8'h09);
        send(5'h03, 8'h11, 4'h4, 1'b0, 1'b0);
        expect_out(8'h11, 8'h09);
        @(posedge clk);
        t1_format <= payload_pkg::FMT_DM;
        send(5'h03, 8'h11, 4'h4, 1'b0, 1'b0);
        expect_out(8'h11, 8'h04);
        $display("test snapshot done");
        // nibble placement over snapshot, per framing format
        wr(8'hD1, 8'h09);
        foreach (plc[i]) begin
            @(posedge clk);
            t1_format <= 2'(i);
            send(5'h03, 8'h22, 4'hB, 1'b0, 1'b1);
            expect_out(8'h22, plc[i]);
        end
        $display("test placement done");
        // fill the buffer against a stalled backplane, drain slowly
        wr(8'hD1, 8'h00);
        @(posedge clk);
        pace <= 2'h2;
        for (int i = 0; i < 9; i++) send(5'(i), 8'hA0 + 8'(i), 4'(i), 1'b0, 1'b0);
        @(posedge clk);
        check("rx_ready full", {7'h00, rx_ready}, 8'h00);
        pace <= 2'h1;
        for (int i = 0; i < 9; i++) expect_out(8'hA0 + 8'(i), 8'(i));
        check("rx_ready empty", {7'h00, rx_ready}, 8'h01);
        $display("test buffer done");
        final_report();
    end
endmodule
